/* ssa_defines.vh */
// shared sram arbiter constants: ram cycle timing and priority
// assumes a 100 MHz mclk; included by the arbiter design file only
`ifndef SSA_DEFINES_VH
`define SSA_DEFINES_VH

// ram cycle: address setup, strobe active, recovery (in mclk cycles)
`define SSA_SETUP_CYC    4'h1
`define SSA_STROBE_CYC   4'h3
`define SSA_RECOVER_CYC  4'h1
// owner codes
`define SSA_OWN_COMM     1'b0
`define SSA_OWN_HOST     1'b1
// tie priority: communications processor wins a same-cycle tie
`define SSA_TIE_OWNER    1'b0

`endif

/* ssa_irq_flag.v */
// ssa_irq_flag: one sticky interprocessor interrupt flag
// assumes set and clear are single-cycle pulses on mclk
`timescale 1ns/1ns

module ssa_irq_flag
(
    input  wire mclk,
    input  wire rst_n,
    input  wire set_pulse,
    input  wire clr_pulse,
    output reg  flag
);

always @(posedge mclk)
begin
    if (!rst_n)
        flag <= 1'b0;
    else if (set_pulse)
        flag <= 1'b1; // set wins over a same-cycle clear
    else if (clr_pulse)
        flag <= 1'b0;
end

endmodule // ssa_irq_flag

/* ssa_shared_memory_arbiter.v */
// ssa_shared_memory_arbiter: makes one static ram dual-ported between
// a communications processor (comm) and a host processor, plus the
// interprocessor interrupt pair.
// assumes requests are held until ready; host pins are asynchronous
`timescale 1ns/1ns
`include "ssa_defines.vh"

module ssa_shared_memory_arbiter
(
    input  wire mclk,
    input  wire rst_n,
    input  wire comm_req,
    input  wire comm_wr,
    output reg  comm_ready,
    input  wire host_req_pin,
    input  wire host_wr_pin,
    output reg  host_ready,
    output reg  ram_cs_n,
    output reg  ram_oe_n,
    output reg  ram_we_n,
    output reg  comm_addr_latch_en,
    output reg  comm_data_buf_en,
    output reg  host_addr_latch_en,
    output reg  host_data_buf_en,
    output reg  data_dir_to_ram,
    input  wire comm_host_irq_set,
    input  wire comm_irq_ack_wr,
    input  wire host_irq_clr_pin,
    input  wire host_irq_req_pin,
    output reg  host_irq_out,
    output reg  comm_irq_out
);

localparam ST_IDLE    = 2'd0;
localparam ST_SETUP   = 2'd1;
localparam ST_STROBE  = 2'd2;
localparam ST_RECOVER = 2'd3;

// host pins cross into mclk through two flops
reg  [1:0] host_req_s;
reg  [1:0] host_wr_s;
reg  [1:0] host_clr_s;
reg  [1:0] host_irq_s;
reg        host_clr_d;
reg        host_irq_d;
reg        host_hold;

reg  [1:0] state;
reg  [1:0] next_state;
reg  [3:0] cnt;
reg  [3:0] next_cnt;
reg        owner;
reg        next_owner;
reg        cyc_wr;
reg        next_cyc_wr;
reg        comm_wait;
reg        host_wait;

// synchronizer lag keeps the pin high after ready; hold stops a second access
wire host_req   = host_req_s[1] & ~host_hold;
wire host_wr    = host_wr_s[1];
wire host_clr_p = host_clr_s[1] & ~host_clr_d;
wire host_irq_p = host_irq_s[1] & ~host_irq_d;
wire host_flag;
wire comm_flag;
wire done       = (state == ST_RECOVER) && (cnt == 4'h0);

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        host_req_s <= 2'b00;
        host_wr_s  <= 2'b00;
        host_clr_s <= 2'b00;
        host_irq_s <= 2'b00;
        host_clr_d <= 1'b0;
        host_irq_d <= 1'b0;
    end
    else
    begin
        host_req_s <= {host_req_s[0], host_req_pin};
        host_wr_s  <= {host_wr_s[0], host_wr_pin};
        host_clr_s <= {host_clr_s[0], host_irq_clr_pin};
        host_irq_s <= {host_irq_s[0], host_irq_req_pin};
        host_clr_d <= host_clr_s[1];
        host_irq_d <= host_irq_s[1];
    end
end

// one owner per ram cycle; the waiting side is served next
always @*
begin
    next_state  = state;
    next_cnt    = cnt;
    next_owner  = owner;
    next_cyc_wr = cyc_wr;
    case (state)
        ST_IDLE:
        begin
            if (comm_req && host_req)
            begin
                next_owner = `SSA_TIE_OWNER; // fixed tie priority
                next_state = ST_SETUP;
            end
            else if (comm_req || host_req)
            begin
                next_owner = host_req ? `SSA_OWN_HOST : `SSA_OWN_COMM;
                next_state = ST_SETUP;
            end
            next_cyc_wr = (next_owner == `SSA_OWN_HOST) ? host_wr : comm_wr;
            next_cnt    = `SSA_SETUP_CYC - 4'h1;
        end
        ST_SETUP:
        begin
            if (cnt == 4'h0)
            begin
                next_state = ST_STROBE;
                next_cnt   = `SSA_STROBE_CYC - 4'h1;
            end
            else
                next_cnt = cnt - 4'h1;
        end
        ST_STROBE:
        begin
            if (cnt == 4'h0)
            begin
                next_state = ST_RECOVER;
                next_cnt   = `SSA_RECOVER_CYC - 4'h1;
            end
            else
                next_cnt = cnt - 4'h1;
        end
        ST_RECOVER:
        begin
            if (cnt == 4'h0)
            begin
                // loser of a conflict goes straight after one cycle
                if (owner == `SSA_OWN_COMM && host_wait)
                begin
                    next_owner  = `SSA_OWN_HOST;
                    next_cyc_wr = host_wr;
                    next_state  = ST_SETUP;
                    next_cnt    = `SSA_SETUP_CYC - 4'h1;
                end
                else if (owner == `SSA_OWN_HOST && comm_wait)
                begin
                    next_owner  = `SSA_OWN_COMM;
                    next_cyc_wr = comm_wr;
                    next_state  = ST_SETUP;
                    next_cnt    = `SSA_SETUP_CYC - 4'h1;
                end
                else
                    next_state = ST_IDLE;
            end
            else
                next_cnt = cnt - 4'h1;
        end
        default:
        begin
            next_state = ST_IDLE;
            next_cnt   = 4'h0;
        end
    endcase
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        state     <= ST_IDLE;
        cnt       <= 4'h0;
        owner     <= `SSA_OWN_COMM;
        cyc_wr    <= 1'b0;
        comm_wait <= 1'b0;
        host_wait <= 1'b0;
        host_hold <= 1'b0;
    end
    else
    begin
        // re-arm only once the synchronized host request has dropped
        if (done && owner == `SSA_OWN_HOST)
            host_hold <= 1'b1;
        else if (!host_req_s[1])
            host_hold <= 1'b0;
        state  <= next_state;
        cnt    <= next_cnt;
        owner  <= next_owner;
        cyc_wr <= next_cyc_wr;
        // remember a request that arrived while the other side owns the ram
        comm_wait <= comm_req && !(next_state != ST_IDLE && next_owner == `SSA_OWN_COMM)
                     && !(done && owner == `SSA_OWN_COMM);
        host_wait <= host_req && !(next_state != ST_IDLE && next_owner == `SSA_OWN_HOST)
                     && !(done && owner == `SSA_OWN_HOST);
    end
end

// registered strobes, ready and bus interface enables
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        ram_cs_n           <= 1'b1;
        ram_oe_n           <= 1'b1;
        ram_we_n           <= 1'b1;
        comm_ready         <= 1'b0;
        host_ready         <= 1'b0;
        comm_addr_latch_en <= 1'b0;
        comm_data_buf_en   <= 1'b0;
        host_addr_latch_en <= 1'b0;
        host_data_buf_en   <= 1'b0;
        data_dir_to_ram    <= 1'b0;
    end
    else
    begin
        ram_cs_n <= !(next_state == ST_SETUP || next_state == ST_STROBE);
        ram_oe_n <= !(next_state == ST_STROBE && !next_cyc_wr);
        ram_we_n <= !(next_state == ST_STROBE && next_cyc_wr);
        // ready only at cycle end, so a stalled side just sees wait states
        comm_ready <= done && owner == `SSA_OWN_COMM;
        host_ready <= done && owner == `SSA_OWN_HOST;
        comm_addr_latch_en <= next_state != ST_IDLE && next_owner == `SSA_OWN_COMM;
        host_addr_latch_en <= next_state != ST_IDLE && next_owner == `SSA_OWN_HOST;
        comm_data_buf_en   <= next_state == ST_STROBE && next_owner == `SSA_OWN_COMM;
        host_data_buf_en   <= next_state == ST_STROBE && next_owner == `SSA_OWN_HOST;
        data_dir_to_ram    <= next_cyc_wr;
    end
end

ssa_irq_flag u_host_flag
(
    .mclk      (mclk),
    .rst_n     (rst_n),
    .set_pulse (comm_host_irq_set),
    .clr_pulse (host_clr_p),
    .flag      (host_flag)
);

ssa_irq_flag u_comm_flag
(
    .mclk      (mclk),
    .rst_n     (rst_n),
    .set_pulse (host_irq_p),
    .clr_pulse (comm_irq_ack_wr),
    .flag      (comm_flag)
);

// outputs re-registered so they come from a flop at the top
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        host_irq_out <= 1'b0;
        comm_irq_out <= 1'b0;
    end
    else
    begin
        host_irq_out <= host_flag;
        comm_irq_out <= comm_flag;
    end
end

endmodule // ssa_shared_memory_arbiter

/* ssa_properties.sv */
// ssa_properties: timing checks on the shared ram arbiter's ports
// assumes one mclk domain with synchronous active-low rst_n
`timescale 1ns/1ns

module ssa_properties
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic comm_ready,
    input wire logic host_ready,
    input wire logic ram_cs_n,
    input wire logic ram_oe_n,
    input wire logic ram_we_n,
    input wire logic comm_addr_latch_en,
    input wire logic host_addr_latch_en,
    input wire logic comm_data_buf_en,
    input wire logic host_data_buf_en,
    input wire logic data_dir_to_ram,
    input wire logic comm_host_irq_set,
    input wire logic comm_irq_ack_wr,
    input wire logic host_irq_req_pin,
    input wire logic host_irq_out,
    input wire logic comm_irq_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_one_owner: assert property (!(comm_addr_latch_en && host_addr_latch_en))
        else $error("both address latches enabled");
    a_strobe_in_cs: assert property ((!ram_oe_n || !ram_we_n) |-> !ram_cs_n)
        else $error("strobe outside chip select");
    a_cs_length: assert property ($fell(ram_cs_n) |-> !ram_cs_n [*4] ##1 ram_cs_n)
        else $error("chip select length wrong");
    a_oe_length: assert property ($fell(ram_oe_n) |-> !ram_oe_n [*3] ##1 ram_oe_n)
        else $error("output enable length wrong");
    a_we_dir: assert property (!ram_we_n |-> data_dir_to_ram)
        else $error("write strobe with buffers facing away");
    a_ready_gap: assert property (comm_ready |=> !comm_ready && !host_ready)
        else $error("ready too soon after comm ready");
    a_irq_follows: assert property (comm_host_irq_set |-> ##2 host_irq_out)
        else $error("host irq not raised after set");
    a_set_wins: assert property ($fell(host_irq_out) |-> !$past(comm_host_irq_set, 2))
        else $error("host irq cleared despite set");
    a_buf_strobe: assert property ((comm_data_buf_en || host_data_buf_en) == (!ram_oe_n || !ram_we_n))
        else $error("data buffer enable outside strobe");
    a_buf_single: assert property (!(comm_data_buf_en && host_data_buf_en))
        else $error("both data buffers enabled");
    a_host_single: assert property (host_ready |=> !host_ready [*8])
        else $error("host ready repeated for one request");
    a_ack_clears: assert property (comm_irq_ack_wr && !host_irq_req_pin |-> ##2 !comm_irq_out)
        else $error("comm irq not cleared by ack");

    cover property (comm_ready ##5 host_ready);
    cover property ($rose(host_irq_out));
    cover property ($rose(comm_irq_out));
endmodule // ssa_properties

bind ssa_shared_memory_arbiter ssa_properties i_props (.mclk, .rst_n, .comm_ready, .host_ready,
    .ram_cs_n, .ram_oe_n, .ram_we_n, .comm_addr_latch_en, .host_addr_latch_en,
    .comm_data_buf_en, .host_data_buf_en,
    .data_dir_to_ram, .comm_host_irq_set, .comm_irq_ack_wr, .host_irq_req_pin,
    .host_irq_out, .comm_irq_out);

/* ssa_host_model.sv */
// ssa_host_model: behavioural host processor on the system bus side
// assumes its tasks are called 1 ns after a rising mclk edge
`timescale 1ns/1ns

module ssa_host_model
(
    input  wire mclk,
    input  wire host_ready,
    output reg  host_req_pin,
    output reg  host_wr_pin,
    output reg  host_irq_clr_pin,
    output reg  host_irq_req_pin
);
    initial
    begin
        {host_req_pin, host_wr_pin, host_irq_clr_pin, host_irq_req_pin} = 4'h0;
    end
    // released write line flips so a stale level is never trusted
    always @(posedge mclk)
        if (host_ready)
            {host_req_pin, host_wr_pin} <= #1 {1'b0, ~host_wr_pin};
    task start(input logic wr);
    begin
        host_wr_pin = wr;
        host_req_pin = 1'b1;
    end
    endtask
    // two cycles wide so the pin synchronizer cannot miss it
    task pulse(input logic clr);
    begin
        if (clr)
            host_irq_clr_pin = 1'b1;
        else
            host_irq_req_pin = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        {host_irq_clr_pin, host_irq_req_pin} = 2'h0;
    end
    endtask
endmodule // ssa_host_model

/* ssa_shared_memory_arbiter_tb.sv */
// ssa_shared_memory_arbiter_tb: solo, tied and interrupt scenarios
// assumes the host model stands for the host processor
`timescale 1ns/1ns

module ssa_shared_memory_arbiter_tb;
    reg     mclk, rst_n, comm_req, comm_wr, comm_host_irq_set, comm_irq_ack_wr;
    wire    comm_ready, host_ready, hreq, hwr, hclr, hirq, host_irq_out, comm_irq_out;
    integer mismatches, checks, cyc, base, tc, th;

    ssa_shared_memory_arbiter i_ssa_shared_memory_arbiter (.mclk(mclk), .rst_n(rst_n),
        .comm_req(comm_req), .comm_wr(comm_wr), .comm_ready(comm_ready),
        .host_req_pin(hreq), .host_wr_pin(hwr), .host_ready(host_ready), .ram_cs_n(),
        .ram_oe_n(), .ram_we_n(), .comm_addr_latch_en(), .comm_data_buf_en(),
        .host_addr_latch_en(), .host_data_buf_en(), .data_dir_to_ram(),
        .comm_host_irq_set(comm_host_irq_set), .comm_irq_ack_wr(comm_irq_ack_wr),
        .host_irq_clr_pin(hclr), .host_irq_req_pin(hirq), .host_irq_out(host_irq_out),
        .comm_irq_out(comm_irq_out));
    ssa_host_model i_ssa_host_model (.mclk(mclk), .host_ready(host_ready), .host_req_pin(hreq),
        .host_wr_pin(hwr), .host_irq_clr_pin(hclr), .host_irq_req_pin(hirq));

    task end_sim;
    begin
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge mclk);
        #1;
    end
    endtask
    task chk(input logic ok, input string msg);
    begin
        checks = checks + 1;
        if (ok !== 1'b1)
        begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: %s", $time, msg);
        end
    end
    endtask
    // cycles to each ready; a tie lines the host pin up past its synchronizer
    task run_acc(input logic c, input logic h, input logic wr);
        integer n;
    begin
        tc = -1;
        th = -1;
        if (h)
            i_ssa_host_model.start(wr);
        if (h && c)
            tick(2);
        comm_wr = wr;
        comm_req = c;
        for (n = 1; n <= 20; n = n + 1)
        begin
            tick(1);
            if (comm_ready === 1'b1)
                tc = n;
            if (host_ready === 1'b1)
                th = n;
            comm_req = comm_req & ~comm_ready;
        end
    end
    endtask
    task t_solo;
    begin
        run_acc(1'b1, 1'b0, 1'b0);
        base = tc;
        chk(base == 6, "comm read latency");
        run_acc(1'b1, 1'b0, 1'b1);
        chk(tc == base, "comm write latency differs");
        run_acc(1'b0, 1'b1, 1'b1);
        chk(th == base + 2, "host solo latency");
    end
    endtask
    task t_tie(input logic wr);
    begin
        run_acc(1'b1, 1'b1, wr);
        chk(tc == base, "comm lost a tie");
        chk(th == tc + 5, "host not served one cycle later");
    end
    endtask
    task t_irq;
    begin
        comm_host_irq_set = 1'b1;
        tick(1);
        comm_host_irq_set = 1'b0;
        tick(6);
        chk(host_irq_out === 1'b1, "host irq did not hold");
        // set lands on the edge that takes the synchronized clear
        fork
            i_ssa_host_model.pulse(1'b1);
            begin
                tick(2);
                comm_host_irq_set = 1'b1;
                tick(1);
                comm_host_irq_set = 1'b0;
            end
        join
        tick(6);
        chk(host_irq_out === 1'b1, "clear beat a same-cycle set");
        i_ssa_host_model.pulse(1'b1);
        tick(6);
        chk(host_irq_out === 1'b0, "host irq not cleared");
        i_ssa_host_model.pulse(1'b0);
        tick(6);
        chk(comm_irq_out === 1'b1, "comm irq not raised");
        comm_irq_ack_wr = 1'b1;
        tick(1);
        comm_irq_ack_wr = 1'b0;
        tick(2);
        chk(comm_irq_out === 1'b0, "comm irq not acknowledged");
    end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 1000)
        begin
            mismatches = mismatches + 1;
            end_sim;
        end
    end
    initial
    begin
        {rst_n, comm_req, comm_wr, comm_host_irq_set, comm_irq_ack_wr} = 5'h0;
        {mismatches, checks, cyc} = 0;
        tick(6);
        rst_n = 1'b1;
        tick(3);
        t_solo;
        t_tie(1'b0);
        t_tie(1'b1);
        t_irq;
        end_sim;
    end
endmodule // ssa_shared_memory_arbiter_tb
